// ===== verilog/lds_pkg.sv
// Constants for the load diagnostic and fault supervisor
`default_nettype none
package lds_pkg;
   // Clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int DIAG_TIME_MS = 229;
   localparam int DIAG_CYCLES = DIAG_TIME_MS * (CLK_HZ / 1000);
   localparam int DIAG_CNT_W = 23;
   localparam int MAX_CHECKS = 5;
   localparam int PWM_PERIOD = 256;
   localparam int PWM_HALF = PWM_PERIOD / 2;
   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_STAT = 3'h0;
   localparam logic [2:0] IDX_DIAG = 3'h1;
   localparam logic [2:0] IDX_CTRL = 3'h2;
   localparam logic [2:0] IDX_CFG = 3'h3;
   localparam int ADDR_W = 5;
   // Status bit positions (sticky, write one to clear)
   localparam int ST_OC = 0;
   localparam int ST_DC = 1;
   localparam int ST_OT = 2;
   localparam int ST_UV = 3;
   localparam int ST_OV = 4;
   localparam int ST_LOAD = 5;
   localparam int STAT_W = 6;
   // Diagnostic register fields
   localparam int DG_RES_LSB = 0;
   localparam int DG_RUN = 3;
   localparam int DG_FLT = 4;
   // Control register fields
   localparam int CT_HIZ = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Configuration register: output limit in 5:0
   localparam int CF_LIM_LSB = 0;
   localparam int CF_LIM_W = 6;
   localparam logic [7:0] CFG_RST = 8'h3F;
   // Synchronised pin vector positions
   localparam int PIN_STBY = 0;
   localparam int PIN_OC = 1;
   localparam int PIN_DC = 2;
   localparam int PIN_OT = 3;
   localparam int PIN_UV = 4;
   localparam int PIN_OV = 5;
   localparam int PIN_POR = 6;
   localparam int PIN_GND = 7;
   localparam int PIN_SUP = 8;
   localparam int PIN_ACR = 9;
   localparam int PIN_OPEN = 10;
   localparam int PIN_CAP = 11;
   localparam int PIN_W = 12;
   // Diagnostic result codes
   typedef enum logic [2:0] {
      RES_NONE, RES_NORMAL, RES_GND, RES_SUP, RES_ACROSS, RES_OPEN
   } lds_res_e;
   typedef enum logic [1:0] {ST_OFF, ST_DIAG, ST_RUN, ST_FAULT} lds_state_e;
endpackage
`default_nettype wire

// ===== verilog/lds_supervisor.sv
// Load diagnostic, protection and PWM supervisor with Avalon-MM registers
// Overview of operation
// RULE_01: Leaving standby or any fault state starts the load diagnostic.
// RULE_02: Bridge outputs stay tri-stated while the diagnostic runs.
// RULE_03: Result is ground short, supply short, open load or across-load short.
// RULE_04: One diagnostic pass lasts about 229 ms, set by a parameter.
// RULE_05: Check repeats up to five times on fault or large output capacitance.
// RULE_06: Open load still lets the output stage drive signal.
// RULE_07: Other load faults keep outputs tri-stated and recheck until cleared.
// RULE_08: A normal load result starts driving the outputs.
// RULE_09: Only every second overvoltage event runs the diagnostic.
// RULE_10: Open load goes to status only; other faults also assert fault pin.
// RULE_11: Overtemperature, overvoltage or undervoltage aborts a running diagnostic.
// RULE_12: Overcurrent tri-states outputs, asserts fault pin, records status.
// RULE_13: DC offset is watched while running; it asserts fault and records status.
// RULE_14: Overtemperature shuts down, flags, records, and resumes once cleared.
// RULE_15: Undervoltage asserts fault and returns registers to reset values.
// RULE_16: Power-on reset releases the bus; recovery restarts with default registers.
// RULE_17: Overvoltage asserts the fault pin and records status.
// RULE_18: One configured limit clamps both positive and negative output excursion.
// RULE_19: Zero input switches both bridge outputs in phase.
// RULE_20: Positive output makes positive duty above half; negative reverses it.
// RULE_21: Standby low shuts down, idles the bus and resets all registers.
// RULE_22: Fault pin is active-low open-drain, asserted while protection tri-states.
// RULE_23: Fault pin stays asserted while a fault persists, releases when cleared.
`default_nettype none
module lds_supervisor #(
   parameter int DIAG_CYC = lds_pkg::DIAG_CYCLES,
   parameter int PWM_PER = lds_pkg::PWM_PERIOD
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [lds_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic standby_n,
   input wire logic overcurrent_trip,
   input wire logic dc_offset_trip,
   input wire logic overtemp_trip,
   input wire logic supply_low_event,
   input wire logic supply_high_event,
   input wire logic por_event,
   input wire logic load_gnd_short,
   input wire logic load_sup_short,
   input wire logic load_across_short,
   input wire logic load_open,
   input wire logic load_big_cap,
   input wire logic signed [7:0] signal_level,
   output logic bridge_out_pos,
   output logic bridge_out_neg,
   output logic outputs_tristated,
   output logic fault_o,
   output logic fault_oe_n,
   output logic bus_idle
);
   logic [lds_pkg::PIN_W-1:0] meta_q;
   logic [lds_pkg::PIN_W-1:0] pin_q;
   logic stby_s, oc_s, dc_s, ot_s, uv_s, ov_s, por_s;
   logic reg_clr;
   lds_pkg::lds_state_e state_q;
   logic [lds_pkg::DIAG_CNT_W-1:0] dcnt_q;
   logic [2:0] checks_q;
   logic diag_fault_q;
   lds_pkg::lds_res_e res_q;
   lds_pkg::lds_res_e cls;
   logic pass_end, load_bad, any_fault, abort_diag;
   logic ov_par_q, skip_diag_q;
   logic [lds_pkg::STAT_W-1:0] stat_q;
   logic [7:0] ctrl_q, cfg_q;
   logic ack_q, wr_go, rd_go;
   logic [7:0] pwm_q;
   logic [6:0] lim;
   logic signed [8:0] lvl;
   logic tri_st, fault_act;

   // Decodes a word-aligned register index
   function automatic logic hit(input logic [lds_pkg::ADDR_W-1:0] a, input logic [2:0] idx);
      hit = (a[1:0] == 2'h0) && (a[lds_pkg::ADDR_W-1:2] == idx);
   endfunction

   // Two-flop synchroniser for all pins
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         pin_q <= '0;
      end else begin
         meta_q <= {load_big_cap, load_open, load_across_short, load_sup_short,
                    load_gnd_short, por_event, supply_high_event, supply_low_event,
                    overtemp_trip, dc_offset_trip, overcurrent_trip, standby_n};
         pin_q <= meta_q;
      end
   end
   assign stby_s = pin_q[lds_pkg::PIN_STBY];
   assign oc_s = pin_q[lds_pkg::PIN_OC];
   assign dc_s = pin_q[lds_pkg::PIN_DC];
   assign ot_s = pin_q[lds_pkg::PIN_OT];
   assign uv_s = pin_q[lds_pkg::PIN_UV];
   assign ov_s = pin_q[lds_pkg::PIN_OV];
   assign por_s = pin_q[lds_pkg::PIN_POR];

   // RULE_15 RULE_16 RULE_21 register reset sources
   assign reg_clr = !stby_s || por_s || uv_s;
   // RULE_16 RULE_21 bus released
   assign bus_idle = !stby_s || por_s;
   assign any_fault = oc_s || dc_s || ot_s || uv_s || ov_s;
   // RULE_11 diagnostic abort
   assign abort_diag = ot_s || ov_s || uv_s;
   // RULE_04 pass length
   assign pass_end = (dcnt_q == lds_pkg::DIAG_CNT_W'(DIAG_CYC - 1));
   // RULE_03 result classification
   always_comb begin
      if (pin_q[lds_pkg::PIN_GND]) begin
         cls = lds_pkg::RES_GND;
      end else if (pin_q[lds_pkg::PIN_SUP]) begin
         cls = lds_pkg::RES_SUP;
      end else if (pin_q[lds_pkg::PIN_ACR]) begin
         cls = lds_pkg::RES_ACROSS;
      end else if (pin_q[lds_pkg::PIN_OPEN]) begin
         cls = lds_pkg::RES_OPEN;
      end else begin
         cls = lds_pkg::RES_NORMAL;
      end
   end
   assign load_bad = (cls != lds_pkg::RES_NORMAL) && (cls != lds_pkg::RES_OPEN);
   // Supervisor state machine
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= lds_pkg::ST_OFF;
      end else if (!stby_s || por_s) begin
         state_q <= lds_pkg::ST_OFF;
      end else begin
         case (state_q)
            // RULE_01 diagnostic after standby
            lds_pkg::ST_OFF: begin
               state_q <= lds_pkg::ST_DIAG;
            end
            lds_pkg::ST_DIAG: begin
               // RULE_11 abort on fault
               if (abort_diag) begin
                  state_q <= lds_pkg::ST_FAULT;
               // RULE_06 RULE_08 start driving
               end else if (pass_end && !load_bad && !pin_q[lds_pkg::PIN_CAP]) begin
                  state_q <= lds_pkg::ST_RUN;
               end else if (pass_end && !load_bad && checks_q == 3'(lds_pkg::MAX_CHECKS - 1)) begin
                  state_q <= lds_pkg::ST_RUN;
               end
            end
            lds_pkg::ST_RUN: begin
               // RULE_12 RULE_13 RULE_14 RULE_17 shutdown
               if (any_fault) begin
                  state_q <= lds_pkg::ST_FAULT;
               end
            end
            lds_pkg::ST_FAULT: begin
               // RULE_01 RULE_09 RULE_14 recovery
               if (!any_fault) begin
                  state_q <= skip_diag_q ? lds_pkg::ST_RUN : lds_pkg::ST_DIAG;
               end
            end
            default: begin
               state_q <= lds_pkg::ST_OFF;
            end
         endcase
      end
   end

   // RULE_04 RULE_05 RULE_07 pass counter and check repeats
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dcnt_q <= '0;
         checks_q <= 3'h0;
      end else if (state_q != lds_pkg::ST_DIAG) begin
         dcnt_q <= '0;
         checks_q <= 3'h0;
      end else if (pass_end) begin
         dcnt_q <= '0;
         if ((load_bad || pin_q[lds_pkg::PIN_CAP])
             && checks_q != 3'(lds_pkg::MAX_CHECKS - 1)) begin
            checks_q <= checks_q + 3'h1;
         end else begin
            checks_q <= 3'h0;
         end
      end else begin
         dcnt_q <= dcnt_q + 1'b1;
      end
   end

   // RULE_07 RULE_10 held load fault and result
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         diag_fault_q <= 1'b0;
         res_q <= lds_pkg::RES_NONE;
      end else if (reg_clr) begin
         diag_fault_q <= 1'b0;
         res_q <= lds_pkg::RES_NONE;
      end else if (state_q == lds_pkg::ST_DIAG && pass_end) begin
         if (!load_bad) begin
            diag_fault_q <= 1'b0;
            res_q <= cls;
         end else if (checks_q == 3'(lds_pkg::MAX_CHECKS - 1)) begin
            diag_fault_q <= 1'b1;
            res_q <= cls;
         end
      end
   end

   // RULE_09 overvoltage alternation
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ov_par_q <= 1'b0;
         skip_diag_q <= 1'b0;
      end else if (!stby_s || por_s) begin
         ov_par_q <= 1'b0;
         skip_diag_q <= 1'b0;
      end else if (state_q != lds_pkg::ST_FAULT && abort_diag
                   && (state_q == lds_pkg::ST_RUN || state_q == lds_pkg::ST_DIAG)) begin
         if (ov_s && !ot_s && !uv_s) begin
            ov_par_q <= !ov_par_q;
            skip_diag_q <= !ov_par_q;
         end else begin
            skip_diag_q <= 1'b0;
         end
      end else if (state_q == lds_pkg::ST_RUN && any_fault) begin
         skip_diag_q <= 1'b0;
      end
   end

   // Avalon one-wait-state handshake
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wr_go = avs_write && ack_q && avs_byteenable[0];
   assign rd_go = avs_read && !ack_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // RULE_10 RULE_12 RULE_13 RULE_14 RULE_15 RULE_17 sticky status, set wins
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stat_q <= '0;
      end else begin
         logic [lds_pkg::STAT_W-1:0] setv;
         setv = '0;
         setv[lds_pkg::ST_OC] = oc_s;
         setv[lds_pkg::ST_DC] = dc_s && state_q == lds_pkg::ST_RUN;
         setv[lds_pkg::ST_OT] = ot_s;
         setv[lds_pkg::ST_UV] = uv_s;
         setv[lds_pkg::ST_OV] = ov_s;
         setv[lds_pkg::ST_LOAD] = state_q == lds_pkg::ST_DIAG && pass_end && cls != lds_pkg::RES_NORMAL;
         if (reg_clr) begin
            stat_q <= setv;
         end else if (wr_go && hit(avs_address, lds_pkg::IDX_STAT)) begin
            stat_q <= (stat_q & ~avs_writedata[lds_pkg::STAT_W-1:0]) | setv;
         end else begin
            stat_q <= stat_q | setv;
         end
      end
   end

   // RULE_15 RULE_16 RULE_21 control and configuration registers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= lds_pkg::CTRL_RST;
         cfg_q <= lds_pkg::CFG_RST;
      end else if (reg_clr) begin
         ctrl_q <= lds_pkg::CTRL_RST;
         cfg_q <= lds_pkg::CFG_RST;
      end else if (wr_go) begin
         if (hit(avs_address, lds_pkg::IDX_CTRL)) begin
            ctrl_q <= avs_writedata[7:0];
         end
         if (hit(avs_address, lds_pkg::IDX_CFG)) begin
            cfg_q <= avs_writedata[7:0];
         end
      end
   end

   // Read data, unmapped reads return zero
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         avs_readdata <= 32'h0;
      end else if (rd_go) begin
         avs_readdata <= 32'h0;
         if (hit(avs_address, lds_pkg::IDX_STAT)) begin
            avs_readdata <= {26'h0, stat_q};
         end else if (hit(avs_address, lds_pkg::IDX_DIAG)) begin
            avs_readdata <= {27'h0, diag_fault_q, state_q == lds_pkg::ST_DIAG, res_q};
         end else if (hit(avs_address, lds_pkg::IDX_CTRL)) begin
            avs_readdata <= {24'h0, ctrl_q};
         end else if (hit(avs_address, lds_pkg::IDX_CFG)) begin
            avs_readdata <= {24'h0, cfg_q};
         end
      end
   end

   // RULE_18 symmetric clamp
   assign lim = {cfg_q[lds_pkg::CF_LIM_LSB +: lds_pkg::CF_LIM_W], 1'b1};
   always_comb begin
      lvl = 9'(signal_level);
      if (lvl > $signed({2'b00, lim})) begin
         lvl = $signed({2'b00, lim});
      end else if (lvl < -$signed({2'b00, lim})) begin
         lvl = -$signed({2'b00, lim});
      end
   end
   // RULE_02 RULE_06 RULE_07 RULE_08 output tri-state
   assign tri_st = state_q != lds_pkg::ST_RUN || ctrl_q[lds_pkg::CT_HIZ];

   // RULE_19 RULE_20 in-phase modulator
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_q <= 8'h00;
         bridge_out_pos <= 1'b0;
         bridge_out_neg <= 1'b0;
         outputs_tristated <= 1'b1;
      end else begin
         pwm_q <= (pwm_q == 8'(PWM_PER - 1)) ? 8'h00 : pwm_q + 8'h01;
         outputs_tristated <= tri_st;
         bridge_out_pos <= !tri_st && ($signed({2'b00, pwm_q}) < 11'(PWM_PER / 2) + 11'(lvl));
         bridge_out_neg <= !tri_st && ($signed({2'b00, pwm_q}) < 11'(PWM_PER / 2) - 11'(lvl));
      end
   end

   // RULE_10 RULE_22 RULE_23 open-drain fault indicator
   assign fault_act = state_q == lds_pkg::ST_FAULT || diag_fault_q;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fault_oe_n <= 1'b1;
      end else begin
         fault_oe_n <= !fault_act;
      end
   end
   assign fault_o = 1'b0;

   // RULE_02 diagnostic holds hi-z
   diag_hiz_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_02
      state_q == lds_pkg::ST_DIAG |=> outputs_tristated && !bridge_out_pos)
      else $error("outputs driven during diagnostic");
   // RULE_11 abort check
   diag_abort_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_11
      state_q == lds_pkg::ST_DIAG && abort_diag && stby_s && !por_s
      |=> state_q == lds_pkg::ST_FAULT)
      else $error("diagnostic not abandoned on fault");
   // RULE_12 overcurrent check
   oc_shutdown_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_12
      state_q == lds_pkg::ST_RUN && oc_s && stby_s && !por_s
      |=> stat_q[lds_pkg::ST_OC] ##1 (outputs_tristated && !fault_oe_n))
      else $error("overcurrent not handled");
   // RULE_13 dc offset check
   dc_detect_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_13
      state_q == lds_pkg::ST_RUN && dc_s && !uv_s && stby_s && !por_s
      |=> stat_q[lds_pkg::ST_DC] && state_q == lds_pkg::ST_FAULT)
      else $error("dc offset not handled");
   // RULE_14 automatic resume
   ot_resume_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_14
      state_q == lds_pkg::ST_FAULT && !any_fault && !skip_diag_q && stby_s && !por_s
      |=> state_q == lds_pkg::ST_DIAG)
      else $error("no diagnostic after fault cleared");
   // RULE_15 undervoltage register reset
   uv_regs_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_15
      uv_s |=> cfg_q == lds_pkg::CFG_RST && ctrl_q == lds_pkg::CTRL_RST && stat_q[lds_pkg::ST_UV])
      else $error("registers not reset on undervoltage");
   // RULE_21 standby shutdown
   standby_off_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_21
      !stby_s |-> bus_idle ##1 state_q == lds_pkg::ST_OFF ##1 outputs_tristated)
      else $error("standby not honoured");
   // RULE_06 open load still drives
   open_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_06
      state_q == lds_pkg::ST_DIAG && pass_end && cls == lds_pkg::RES_OPEN && !pin_q[lds_pkg::PIN_CAP]
      && !abort_diag && stby_s && !por_s |=> state_q == lds_pkg::ST_RUN ##1 fault_oe_n)
      else $error("open load blocked output");
   // RULE_20 duty relation
   duty_order_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_20
      signal_level > 0 |=> bridge_out_pos || !bridge_out_neg)
      else $error("positive duty relation broken");
   // RULE_19 in-phase at zero
   zero_phase_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_19
      signal_level == 0 |=> bridge_out_pos == bridge_out_neg)
      else $error("outputs not in phase at zero");
   // RULE_05 check repeat bound
   check_limit_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_05
      checks_q < 3'(lds_pkg::MAX_CHECKS))
      else $error("too many check repeats");

   run_cov: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_q == lds_pkg::ST_DIAG ##1 state_q == lds_pkg::ST_RUN);
   fault_cov: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_q == lds_pkg::ST_RUN ##1 state_q == lds_pkg::ST_FAULT);
   skip_cov: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_q == lds_pkg::ST_FAULT && skip_diag_q ##1 state_q == lds_pkg::ST_RUN);
endmodule // lds_supervisor
`default_nettype wire

// ===== testbench/lds_host_model.sv
// Host-side model of the open-drain fault line with its pull-up
`default_nettype none
module lds_host_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic fault_o,
   input wire logic fault_oe_n,
   output logic fault_line,
   output int alert_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic line_q;
   // Pull-up holds the line high unless the device sinks it
   assign fault_line = fault_oe_n ? 1'b1 : fault_o;
   // Counts each new alert seen by the host
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         line_q <= 1'b1;
         alert_cnt <= 0;
      end else begin
         line_q <= fault_line;
         alert_cnt <= alert_cnt + int'(line_q && !fault_line);
      end
   end
endmodule // lds_host_model
`default_nettype wire

// ===== testbench/lds_supervisor_tb.sv
// Self-checking bench for the load diagnostic and fault supervisor
`default_nettype none
module lds_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DC = 40;
   logic ref_clk, nrst, rd, wr, wq, stby_n, por, cap, pos, neg, tri_o, f_o, f_oe_n, idle;
   logic fline;
   logic [4:0] addr, flt;
   logic [3:0] be, ld;
   logic [31:0] wdata, rdata, rv;
   logic signed [7:0] lvl, v;
   logic [16:0] lf;
   int alerts, n, p1, q1, p2, q2, ph, a0;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int rec [2];

   lds_supervisor #(.DIAG_CYC(DC), .PWM_PER(256)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wq), .standby_n(stby_n), .overcurrent_trip(flt[0]),
      .dc_offset_trip(flt[1]), .overtemp_trip(flt[2]), .supply_low_event(flt[3]),
      .supply_high_event(flt[4]), .por_event(por), .load_gnd_short(ld[0]),
      .load_sup_short(ld[1]), .load_across_short(ld[2]), .load_open(ld[3]),
      .load_big_cap(cap), .signal_level(lvl), .bridge_out_pos(pos), .bridge_out_neg(neg),
      .outputs_tristated(tri_o), .fault_o(f_o), .fault_oe_n(f_oe_n), .bus_idle(idle));
   lds_host_model host (.ref_clk(ref_clk), .nrst(nrst), .fault_o(f_o),
      .fault_oe_n(f_oe_n), .fault_line(fline), .alert_cnt(alerts));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do tick(1); while (wq !== 1'b0);
      rv = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      tick(1);
   endtask

   task automatic rdm(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rv & m, e);
   endtask

   task automatic wait_run();
      n = 0;
      while (tri_o !== 1'b0 && n < 40 * DC) begin
         tick(1);
         n++;
      end
   endtask

   task automatic stby();
      stby_n <= 1'b0;
      tick(6);
      stby_n <= 1'b1;
   endtask

   // Counts high cycles of each bridge output over one full period
   task automatic duty(input logic signed [7:0] x, output int p, output int q);
      lvl <= x;
      tick(260);
      p = 0;
      q = 0;
      repeat (256) begin
         tick(1);
         p += int'(pos === 1'b1);
         q += int'(neg === 1'b1);
         ph += int'(pos !== neg);
      end
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      {nrst, rd, wr, stby_n, por, cap, flt, ld} = '0;
      lvl = 8'sh00;
      addr = 5'h00;
      wdata = 32'h0;
      be = 4'hF;
      lf = 17'd83179;
      ph = 0;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      tick(2);
      chk(idle, 1'b1);
      rdm(5'h0C, 32'hFF, 32'h3F);
      rdm(5'h08, 32'hFF, 32'h00);
      rdm(5'h10, 32'hFFFFFFFF, 32'h0);
      stby_n <= 1'b1;
      wait_run();
      chk(n >= DC && n <= DC + 10, 1'b1);
      rdm(5'h04, 32'h07, 32'h01);
      chk(idle, 1'b0);
      // Forced tri-state from the control register, then released
      bus(1'b1, 5'h08, 32'h01);
      tick(1);
      chk(tri_o, 1'b1);
      rdm(5'h08, 32'hFF, 32'h01);
      bus(1'b1, 5'h08, 32'h00);
      wait_run();
      chk(tri_o, 1'b0);
      cap <= 1'b1;
      stby();
      wait_run();
      chk(n >= 5 * DC && n <= 5 * DC + 30, 1'b1);
      cap <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         ld <= 4'(1 << i);
         a0 = alerts;
         stby();
         tick(7 * DC);
         chk(tri_o, i != 3);
         chk(fline, i == 3);
         chk(alerts > a0, i != 3);
         rdm(5'h04, 32'h07, i + 2);
         rdm(5'h00, 32'h20, 32'h20);
         ld <= 4'h0;
         wait_run();
         chk(fline, 1'b1);
      end
      be <= 4'hE;
      bus(1'b1, 5'h00, 32'hFF);
      be <= 4'hF;
      rdm(5'h00, 32'h20, 32'h20);
      bus(1'b1, 5'h00, 32'hFF);
      rdm(5'h00, 32'hFF, 32'h00);
      for (int i = 0; i < 3; i++) begin
         flt <= 5'(1 << i);
         tick(6);
         chk(tri_o, 1'b1);
         chk(fline, 1'b0);
         rdm(5'h00, 32'h07, 32'(1 << i));
         flt <= 5'h0;
         wait_run();
         chk(n >= DC && n < 40 * DC, 1'b1);
         chk(fline, 1'b1);
         bus(1'b1, 5'h00, 32'hFF);
      end
      bus(1'b1, 5'h0C, 32'h15);
      flt <= 5'h08;
      tick(6);
      chk(fline, 1'b0);
      rdm(5'h0C, 32'hFF, 32'h3F);
      flt <= 5'h0;
      wait_run();
      stby();
      wait_run();
      for (int k = 0; k < 2; k++) begin
         flt <= 5'h10;
         tick(6);
         chk(fline, 1'b0);
         rdm(5'h00, 32'h10, 32'h10);
         flt <= 5'h0;
         wait_run();
         rec[k] = n;
      end
      chk(rec[1] > rec[0] + DC / 2, 1'b1);
      stby();
      tick(8);
      rdm(5'h04, 32'h08, 32'h08);
      flt <= 5'h04;
      tick(6);
      rdm(5'h04, 32'h08, 32'h00);
      flt <= 5'h0;
      wait_run();
      for (int k = 0; k < 6; k++) begin
         lf = lfsr_next(lf);
         v = 8'(32 + lf[4:0]);
         if (lf[7]) v = -v;
         duty(v, p1, q1);
         chk(p1 > q1, v > 0);
      end
      ph = 0;
      duty(8'sd0, p1, q1);
      chk(ph, 0);
      bus(1'b1, 5'h0C, 32'h08);
      duty(8'sd100, p1, q1);
      duty(8'sd17, p2, q2);
      chk(p1, p2);
      duty(-8'sd100, p1, q1);
      duty(-8'sd17, p2, q2);
      chk(q1, q2);
      por <= 1'b1;
      tick(6);
      chk(idle, 1'b1);
      por <= 1'b0;
      wait_run();
      chk(tri_o, 1'b0);
      rdm(5'h0C, 32'hFF, 32'h3F);
      tally_and_finish();
   end
endmodule // lds_supervisor_tb
`default_nettype wire
